// ---- hw/slpc_cfg.svh ----
// constants and behaviour notes for the sleep mode controller
// Notes on behaviour
// - mode 0 none,1 hibernate,2 doze,4/5 cyclic
// - mode 3 reserved; 6 legacy coordinator
// - option bit 0 skips wake-up poll
// - option bit 1 suppresses wake-up sample
// - inactivity timeout in ms puts node asleep
// - inactivity timeout only in modes 4, 5
// - cyclic sleep lasts period times 10 ms
// - held message dropped after 2.5 periods
// - unassociated node sleeps orphan period, retries
// - orphan period 10 ms units, default 0x3e8
`ifndef SLPC_CFG_SVH
`define SLPC_CFG_SVH
`define SLPC_CLK_HZ        20000000
`define SLPC_MS_TICK_CYC   (`SLPC_CLK_HZ / 1000)
`define SLPC_MS_PER_TEN    4'h9
`define SLPC_MODE_NONE     8'h00
`define SLPC_MODE_HIB      8'h01
`define SLPC_MODE_DOZE     8'h02
`define SLPC_MODE_RSVD     8'h03
`define SLPC_MODE_CYC      8'h04
`define SLPC_MODE_CYC_PIN  8'h05
`define SLPC_MODE_LEGACY   8'h06
`define SLPC_OPT_NOPOLL    0
`define SLPC_OPT_NOSAMP    1
`define SLPC_RST_MODE      8'h00
`define SLPC_RST_OPT       8'h00
`define SLPC_RST_TIMEOUT   16'h1388
`define SLPC_RST_PERIOD    16'h0000
`define SLPC_RST_ORPHAN    16'h03e8
`define SLPC_MAX_PERIOD    16'h68b0
`define SLPC_HOLD_MS_UNIT  20'd25
`define SLPC_SEL_MODE      3'h0
`define SLPC_SEL_OPT       3'h1
`define SLPC_SEL_TIMEOUT   3'h2
`define SLPC_SEL_PERIOD    3'h3
`define SLPC_SEL_ORPHAN    3'h4
`endif

// ---- hw/slpc_ms_tick.sv ----
// divider that pulses once per millisecond and once per ten milliseconds
`timescale 1ns/1ns
`include "slpc_cfg.svh"
module slpc_ms_tick #(
   parameter int CYC_PER_MS = `SLPC_MS_TICK_CYC
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // tick outputs
   output logic      tick_1ms,
   output logic      tick_10ms
);
   logic [31:0] cyc_q;   // cycles within the millisecond
   logic [3:0]  ms_q;    // milliseconds within ten
   // cycle divider
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         cyc_q    <= 32'h0;
         tick_1ms <= 1'b0;
      end
      else if (cyc_q == 32'(CYC_PER_MS - 1))
      begin
         cyc_q    <= 32'h0;
         tick_1ms <= 1'b1;
      end
      else
      begin
         cyc_q    <= cyc_q + 32'h1;
         tick_1ms <= 1'b0;
      end
   end
   // decade divider on the millisecond tick
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         ms_q      <= 4'h0;
         tick_10ms <= 1'b0;
      end
      else
      begin
         tick_10ms <= 1'b0;
         if (tick_1ms)
         begin
            if (ms_q == `SLPC_MS_PER_TEN)
            begin
               ms_q      <= 4'h0;
               tick_10ms <= 1'b1;
            end
            else
               ms_q <= ms_q + 4'h1;
         end
      end
   end
endmodule

// ---- hw/slpc_pkg.sv ----
// types shared by the sleep mode controller files
package slpc_pkg;
   // operating state of the controller
   typedef enum logic [2:0] {
      SLPC_AWAKE  = 3'b000,
      SLPC_CYC_SL = 3'b001,
      SLPC_ORPH_SL= 3'b010,
      SLPC_WAKEUP = 3'b011,
      SLPC_PIN_SL = 3'b100
   } slpc_state_t;
   // configuration write request from the command parser
   typedef struct packed {
      logic        wr;
      logic [2:0]  sel;
      logic [15:0] data;
   } slpc_cfg_wr_t;
   // wake-up actions issued as one-cycle pulses
   typedef struct packed {
      logic poll;
      logic sample;
      logic assoc_retry;
   } slpc_wake_t;
endpackage

// ---- hw/slpc_sleep_ctrl.sv ----
// sleep mode controller: config registers, inactivity timer, sleep periods
`timescale 1ns/1ns
`include "slpc_cfg.svh"
module slpc_sleep_ctrl #(
   parameter int CYC_PER_MS = `SLPC_MS_TICK_CYC
) (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   // configuration access from the command parser
   input  wire slpc_pkg::slpc_cfg_wr_t cfg_wr,
   input  wire logic [2:0]            cfg_rd_sel,
   output logic [15:0]                cfg_rd_data,
   // activity and node status
   input  wire logic                  serial_activity,
   input  wire logic                  radio_activity,
   input  wire logic                  assoc_wanted,
   input  wire logic                  associated,
   input  wire logic                  sampling_enabled,
   input  wire logic                  sleep_pin,
   input  wire logic                  is_coordinator,
   // coordinator indirect message holding
   input  wire logic                  msg_queued,
   input  wire logic                  msg_delivered,
   output logic                       msg_discard,
   // sleep outputs
   output logic                       asleep,
   output logic                       doze_sel,
   output logic                       legacy_coord,
   output slpc_pkg::slpc_wake_t       wake,
   output slpc_pkg::slpc_state_t      state
);
   logic [7:0]  mode_q;       // sleep_mode_select
   logic [7:0]  opt_q;        // sleep_option_flags
   logic [15:0] timeout_q;    // inactivity_timeout, 1 ms units
   logic [15:0] period_q;     // cyclic_sleep_period, 10 ms units
   logic [15:0] orphan_q;     // orphan_sleep_period, 10 ms units
   logic [15:0] inact_q;      // remaining awake milliseconds
   logic [15:0] sleep_cnt_q;  // remaining sleep tens of ms
   logic [19:0] hold_q;       // remaining hold in milliseconds, up to 670000
   logic        hold_act_q;   // a held message is pending
   logic        tick_1ms;     // millisecond strobe
   logic        tick_10ms;    // ten millisecond strobe
   logic        cyclic;       // a cyclic mode is selected
   logic        activity;     // any traffic this cycle
   slpc_pkg::slpc_state_t state_d;

   // time base
   slpc_ms_tick #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_tick (
      .clock    (clock),
      .rst_n    (rst_n),
      .tick_1ms (tick_1ms),
      .tick_10ms(tick_10ms)
   );

   assign cyclic   = (mode_q == `SLPC_MODE_CYC) || (mode_q == `SLPC_MODE_CYC_PIN);
   assign activity = serial_activity | radio_activity;

   // configuration registers; out-of-range writes are clamped, except mode writes, which are refused
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         mode_q    <= `SLPC_RST_MODE;
         opt_q     <= `SLPC_RST_OPT;
         timeout_q <= `SLPC_RST_TIMEOUT;
         period_q  <= `SLPC_RST_PERIOD;
         orphan_q  <= `SLPC_RST_ORPHAN;
      end
      else if (cfg_wr.wr)
      begin
         case (cfg_wr.sel)
            `SLPC_SEL_MODE:
               // reserved value 3 and anything above 6 are refused
               if (cfg_wr.data[7:0] != `SLPC_MODE_RSVD && cfg_wr.data[7:0] <= `SLPC_MODE_LEGACY)
                  mode_q <= cfg_wr.data[7:0];
            `SLPC_SEL_OPT:
               opt_q <= cfg_wr.data[7:0];
            `SLPC_SEL_TIMEOUT:
               // zero is outside the range, keep at least 1 ms
               timeout_q <= (cfg_wr.data == 16'h0) ? 16'h1 : cfg_wr.data;
            `SLPC_SEL_PERIOD:
               period_q <= (cfg_wr.data > `SLPC_MAX_PERIOD) ? `SLPC_MAX_PERIOD
                                                           : cfg_wr.data;
            `SLPC_SEL_ORPHAN:
               orphan_q <= (cfg_wr.data == 16'h0) ? 16'h1 :
                           (cfg_wr.data > `SLPC_MAX_PERIOD) ? `SLPC_MAX_PERIOD
                                                             : cfg_wr.data;
            default:
               mode_q <= mode_q;
         endcase
      end
   end

   // register read-back
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         cfg_rd_data <= 16'h0;
      else
      begin
         case (cfg_rd_sel)
            `SLPC_SEL_MODE:    cfg_rd_data <= {8'h0, mode_q};
            `SLPC_SEL_OPT:     cfg_rd_data <= {8'h0, opt_q};
            `SLPC_SEL_TIMEOUT: cfg_rd_data <= timeout_q;
            `SLPC_SEL_PERIOD:  cfg_rd_data <= period_q;
            `SLPC_SEL_ORPHAN:  cfg_rd_data <= orphan_q;
            default:           cfg_rd_data <= 16'h0;
         endcase
      end
   end

   // next state
   always_comb
   begin
      state_d = state;
      case (state)
         slpc_pkg::SLPC_AWAKE:
            if (mode_q == `SLPC_MODE_HIB || mode_q == `SLPC_MODE_DOZE)
            begin
               if (sleep_pin)
                  state_d = slpc_pkg::SLPC_PIN_SL;
            end
            else if (cyclic && !activity && tick_1ms && inact_q <= 16'h1)
            begin
               if (assoc_wanted && !associated)
                  state_d = slpc_pkg::SLPC_ORPH_SL;
               else
                  state_d = slpc_pkg::SLPC_CYC_SL;
            end
         slpc_pkg::SLPC_PIN_SL:
            if (!sleep_pin || !(mode_q == `SLPC_MODE_HIB || mode_q == `SLPC_MODE_DOZE))
               state_d = slpc_pkg::SLPC_WAKEUP;
         slpc_pkg::SLPC_CYC_SL,
         slpc_pkg::SLPC_ORPH_SL:
            // pin wake-up only in mode 5; leaving cyclic modes wakes at once
            if (!cyclic || (mode_q == `SLPC_MODE_CYC_PIN && sleep_pin == 1'b0) ||
                (tick_10ms && sleep_cnt_q <= 16'h1))
               state_d = slpc_pkg::SLPC_WAKEUP;
         slpc_pkg::SLPC_WAKEUP:
            state_d = slpc_pkg::SLPC_AWAKE;
         default:
            state_d = slpc_pkg::SLPC_AWAKE;
      endcase
   end

   // state register
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         state <= slpc_pkg::SLPC_AWAKE;
      else
         state <= state_d;
   end

   // inactivity timer, reloaded on traffic, on wake and outside the cyclic modes
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         inact_q <= `SLPC_RST_TIMEOUT;
      else if (state != slpc_pkg::SLPC_AWAKE || activity)
         inact_q <= timeout_q;
      else if (!cyclic)
         // held full so a switch into a cyclic mode starts a fresh timeout
         inact_q <= timeout_q;
      else if (tick_1ms && inact_q != 16'h0)
         inact_q <= inact_q - 16'h1;
   end

   // sleep period counter, loaded on entering cyclic or orphan sleep
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         sleep_cnt_q <= 16'h0;
      else if (state == slpc_pkg::SLPC_AWAKE && state_d == slpc_pkg::SLPC_ORPH_SL)
         sleep_cnt_q <= orphan_q;
      else if (state == slpc_pkg::SLPC_AWAKE && state_d == slpc_pkg::SLPC_CYC_SL)
         sleep_cnt_q <= period_q;
      else if (tick_10ms && sleep_cnt_q != 16'h0)
         sleep_cnt_q <= sleep_cnt_q - 16'h1;
   end

   // sleep status outputs
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         asleep       <= 1'b0;
         doze_sel     <= 1'b0;
         legacy_coord <= 1'b0;
      end
      else
      begin
         asleep       <= (state_d != slpc_pkg::SLPC_AWAKE) && (state_d != slpc_pkg::SLPC_WAKEUP);
         doze_sel     <= (mode_q == `SLPC_MODE_DOZE);
         legacy_coord <= (mode_q == `SLPC_MODE_LEGACY);
      end
   end

   // wake-up action pulses
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         wake <= '0;
      else
      begin
         wake.poll        <= (state == slpc_pkg::SLPC_WAKEUP) && cyclic &&
                             !opt_q[`SLPC_OPT_NOPOLL];
         wake.sample      <= (state == slpc_pkg::SLPC_WAKEUP) && sampling_enabled &&
                             !opt_q[`SLPC_OPT_NOSAMP];
         wake.assoc_retry <= (state == slpc_pkg::SLPC_ORPH_SL) &&
                             (state_d == slpc_pkg::SLPC_WAKEUP);
      end
   end

   // indirect message hold: 2.5 periods counted in millisecond ticks
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         hold_act_q  <= 1'b0;
         hold_q      <= 20'h0;
         msg_discard <= 1'b0;
      end
      else
      begin
         msg_discard <= 1'b0;
         if (msg_queued && is_coordinator && period_q != 16'h0)
         begin
            hold_act_q <= 1'b1;
            // period x 10 ms x 2.5 = period x 25 ms; 20 bits hold the largest period
            hold_q     <= 20'({4'h0, period_q} * `SLPC_HOLD_MS_UNIT);
         end
         else if (msg_delivered)
            hold_act_q <= 1'b0;
         else if (hold_act_q && tick_1ms)
         begin
            if (hold_q <= 20'h1)
            begin
               hold_act_q  <= 1'b0;
               msg_discard <= 1'b1;
            end
            else
               hold_q <= hold_q - 20'h1;
         end
      end
   end
endmodule

// ---- tb/slpc_sleep_ctrl_bench.sv ----
// self-checking bench for the sleep controller
`timescale 1ns/1ns
module slpc_sleep_ctrl_bench;
   logic                   clock = 1'b0;
   logic                   rst_n = 1'b0;
   slpc_pkg::slpc_cfg_wr_t cfg_wr = '0;
   logic [2:0]             cfg_rd_sel = 3'h0;
   logic [15:0]            cfg_rd_data, r;
   logic                   ser_act, rad_act, traffic_en = 1'b0, rd_vld = 1'b0;
   logic                   assoc_wanted = 1'b0, associated = 1'b1, samp_en = 1'b0;
   logic                   sleep_pin = 1'b0, is_coord = 1'b0, msg_q = 1'b0, msg_dlv = 1'b0;
   logic                   msg_discard, asleep, doze_sel, legacy_coord;
   logic [2:0]             e;
   slpc_pkg::slpc_wake_t   wake;
   slpc_pkg::slpc_state_t  state;
   logic [15:0]            exp_rd[$]; // expected read data
   logic [2:0]             exp_wk[$]; // expected wake pulses
   int                     error_cnt = 0, total_checks = 0, i;
   // 20 MHz clock
   always #25 clock = ~clock;
   slpc_sleep_ctrl #(.CYC_PER_MS(20)) dut_u (
      .clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd_sel(cfg_rd_sel),
      .cfg_rd_data(cfg_rd_data), .serial_activity(ser_act), .radio_activity(rad_act),
      .assoc_wanted(assoc_wanted), .associated(associated), .sampling_enabled(samp_en),
      .sleep_pin(sleep_pin), .is_coordinator(is_coord), .msg_queued(msg_q),
      .msg_delivered(msg_dlv), .msg_discard(msg_discard), .asleep(asleep),
      .doze_sel(doze_sel), .legacy_coord(legacy_coord), .wake(wake), .state(state));
   slpc_traffic_model traffic_u (.clock(clock), .en(traffic_en),
      .serial_activity(ser_act), .radio_activity(rad_act));
   task automatic step();
      @(posedge clock);
      #5;
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // compare one value, report at once
   task automatic cmp(input logic [15:0] x, input logic [15:0] a);
      total_checks++;
      if (a !== x)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t exp %h got %h", $time, x, a);
      end
   endtask
   // compare read-back data
   task automatic cmp_rd(input logic [15:0] x, input logic [15:0] a);
      cmp(x, a);
   endtask
   // compare one set of wake pulses
   task automatic cmp_wk(input logic [2:0] x, input logic [2:0] a);
      cmp(16'(x), 16'(a));
   endtask
   // write: one edge with the strobe up, then one idle edge before the next
   task automatic wr(input logic [2:0] s, input logic [15:0] d);
      cfg_wr = '{wr: 1'b1, sel: s, data: d};
      step();
      cfg_wr.wr = 1'b0;
      step();
   endtask
   // read: data is registered one edge after the select
   task automatic rd(input logic [2:0] s, input logic [15:0] x);
      cfg_rd_sel = s;
      exp_rd.push_back(x);
      step();
      rd_vld = 1'b1;
      step();
      rd_vld = 1'b0;
   endtask
   // bounded wait for asleep to reach v; hit says whether it must
   task automatic watch(input logic v, input int n, input bit hit);
      i = 0;
      while (i < n && asleep !== v)
      begin
         step();
         i++;
      end
      cmp(16'(hit), 16'(i < n));
      if (hit && i >= n)
         stop_test();
   endtask
   // watcher: pops the oldest note when a result shows
   always @(posedge clock)
   begin
      if (rd_vld === 1'b1)
         cmp_rd(exp_rd.pop_front(), cfg_rd_data);
      if (rst_n === 1'b1 && wake !== 3'h0)
         cmp_wk(exp_wk.size() > 0 ? exp_wk.pop_front() : 3'h0, wake);
   end
   initial
   begin
      r = 16'($urandom(32'h69aff1c3));
      repeat (6) step();
      rst_n = 1'b1;
      rd(3'h0, 16'h0000);
      rd(3'h2, 16'h1388);
      rd(3'h3, 16'h0000);
      rd(3'h4, 16'h03e8);
      $display("test reset done");
      for (int m = 0; m < 7; m++)
      begin
         wr(3'h0, 16'(m));
         rd(3'h0, m == 3 ? 16'h0002 : 16'(m));
         cmp(16'(m == 2 || m == 3), 16'(doze_sel));
         cmp(16'(m == 6), 16'(legacy_coord));
      end
      wr(3'h2, 16'h0000);
      rd(3'h2, 16'h0001);
      wr(3'h4, 16'h0000);
      rd(3'h4, 16'h0001);
      wr(3'h3, 16'hffff);
      rd(3'h3, 16'h68b0);
      r = 16'($urandom % 32'h68b1);
      wr(3'h3, r);
      rd(3'h3, r);
      watch(1'b1, 200, 0);
      $display("test registers done");
      wr(3'h2, 16'h0002);
      wr(3'h3, 16'h0001);
      wr(3'h0, 16'h0004);
      for (int o = 0; o < 4; o++)
      begin
         samp_en = 1'($urandom % 2);
         wr(3'h1, 16'(o));
         e = {o[0] == 1'b0, samp_en && o[1] == 1'b0, 1'b0};
         if (e != 3'h0)
            exp_wk.push_back(e);
         watch(1'b1, 200, 1);
         watch(1'b0, 600, 1);
         repeat (3) step();
      end
      cmp(16'(exp_wk.size()), 16'h0000);
      traffic_en = 1'b1;
      watch(1'b1, 400, 0);
      traffic_en = 1'b0;
      watch(1'b1, 200, 1);
      watch(1'b0, 600, 1);
      $display("test cyclic done");
      assoc_wanted = 1'b1;
      associated = 1'b0;
      exp_wk.push_back(3'h1);
      watch(1'b1, 200, 1);
      watch(1'b0, 600, 1);
      repeat (3) step();
      wr(3'h0, 16'h0001);
      cmp(16'(exp_wk.size()), 16'h0000);
      sleep_pin = 1'b1;
      watch(1'b1, 20, 1);
      sleep_pin = 1'b0;
      watch(1'b0, 20, 1);
      $display("test orphan and pin done");
      wr(3'h0, 16'h0000);
      is_coord = 1'b1;
      // a delivered message is never discarded
      msg_q = 1'b1;
      step();
      msg_q = 1'b0;
      repeat (100) step();
      msg_dlv = 1'b1;
      step();
      msg_dlv = 1'b0;
      i = 0;
      while (i < 600 && msg_discard !== 1'b1)
      begin
         step();
         i++;
      end
      cmp(16'h0000, 16'(i < 600));
      // an undelivered message is dropped after 2.5 periods
      msg_q = 1'b1;
      step();
      msg_q = 1'b0;
      i = 0;
      while (i < 700 && msg_discard !== 1'b1)
      begin
         step();
         i++;
      end
      cmp(16'(i > 470 && i < 530), 16'h0001);
      $display("test discard done");
      stop_test();
   end
endmodule

// ---- tb/slpc_sleep_ctrl_props.sv ----
// port checker for the sleep controller
`timescale 1ns/1ns
module slpc_sleep_ctrl_props (
   // clock and reset
   input wire logic                   clock,
   input wire logic                   rst_n,
   // watched ports
   input wire slpc_pkg::slpc_cfg_wr_t cfg_wr,
   input wire logic                   serial_activity,
   input wire logic                   radio_activity,
   input wire logic                   is_coordinator,
   input wire logic                   msg_discard,
   input wire logic                   asleep,
   input wire logic                   doze_sel,
   input wire logic                   legacy_coord,
   input wire slpc_pkg::slpc_wake_t   wake,
   input wire slpc_pkg::slpc_state_t  state
);
   logic [7:0] mode_q; // mirror of the accepted mode
   logic [1:0] opt_q;  // mirror of the option bits
   // follow mode and option writes, skipping refused modes
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         mode_q <= 8'h00;
         opt_q <= 2'h0;
      end
      else if (cfg_wr.wr && cfg_wr.sel == 3'h0 && cfg_wr.data < 16'h0007 && cfg_wr.data != 16'h0003)
         mode_q <= cfg_wr.data[7:0];
      else if (cfg_wr.wr && cfg_wr.sel == 3'h1)
         opt_q <= cfg_wr.data[1:0];
   end
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   sequence s_traffic;
      (serial_activity || radio_activity) && state == slpc_pkg::SLPC_AWAKE &&
      mode_q inside {8'h04, 8'h05};
   endsequence
   sequence s_wake_exit;
      state == slpc_pkg::SLPC_WAKEUP ##1 state == slpc_pkg::SLPC_AWAKE;
   endsequence
   property p_rsvd;
      $stable(mode_q) [*2] |-> doze_sel == (mode_q == 8'h02);
   endproperty
   property p_legacy;
      cfg_wr.wr && cfg_wr.sel == 3'h0 && cfg_wr.data == 16'h0006 |-> ##[1:2] legacy_coord;
   endproperty
   property p_cyc_only;
      state inside {slpc_pkg::SLPC_CYC_SL, slpc_pkg::SLPC_ORPH_SL} |->
         $past(mode_q) inside {8'h04, 8'h05};
   endproperty
   property p_sleep_lvl;
      state inside {slpc_pkg::SLPC_CYC_SL, slpc_pkg::SLPC_ORPH_SL} |-> asleep;
   endproperty
   property p_nopoll;
      wake.poll |-> !$past(opt_q[0]);
   endproperty
   property p_nosamp;
      wake.sample |-> !$past(opt_q[1]);
   endproperty
   property p_traffic;
      s_traffic |=> !$rose(asleep);
   endproperty
   property p_wake;
      state == slpc_pkg::SLPC_WAKEUP |-> s_wake_exit;
   endproperty
   property p_disc;
      msg_discard |-> is_coordinator ##1 !msg_discard;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("doze select off mode");
   a_legacy: assert property (p_legacy) else $error("legacy not set");
   a_cyc_only: assert property (p_cyc_only) else $error("cyclic sleep off mode");
   a_sleep_lvl: assert property (p_sleep_lvl) else $error("asleep low");
   a_nopoll: assert property (p_nopoll) else $error("poll not skipped");
   a_nosamp: assert property (p_nosamp) else $error("sample not skipped");
   a_traffic: assert property (p_traffic) else $error("slept on traffic");
   a_wake: assert property (p_wake) else $error("wake exit wrong");
   a_disc: assert property (p_disc) else $error("discard wrong");
endmodule
bind slpc_sleep_ctrl slpc_sleep_ctrl_props u_props (
   .clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr), .serial_activity(serial_activity),
   .radio_activity(radio_activity), .is_coordinator(is_coordinator),
   .msg_discard(msg_discard), .asleep(asleep), .doze_sel(doze_sel),
   .legacy_coord(legacy_coord), .wake(wake), .state(state));

// ---- tb/slpc_traffic_model.sv ----
// host and radio traffic source for the sleep controller bench
`timescale 1ns/1ns
module slpc_traffic_model (
   // clock and enable
   input  wire logic clock,
   input  wire logic en,
   // traffic pulses
   output logic      serial_activity,
   output logic      radio_activity
);
   logic [4:0] cnt_q = 5'h00; // spacing counter
   // one traffic pulse every 16 cycles, kept well inside the timeout
   always @(posedge clock)
   begin
      #5;
      cnt_q = en ? cnt_q + 5'h01 : 5'h00;
      serial_activity = en && cnt_q == 5'h10;
      radio_activity = en && cnt_q == 5'h00;
   end
endmodule
